// ==== logic/dram_access_refresh_ctrl.v ====
`timescale 1ns/10ps
`include "dram_ctrl_defines.vh"

module dram_access_refresh_ctrl #(
   parameter ADDR_W = 10,
   parameter CNT_W = 4,
   parameter DIV_W = 6,
   parameter LOG_W = 8
) (
   input wire clock,
   input wire srst,
   input wire accessReqN,
   input wire pageHoldN,
   input wire row_hold_select,
   input wire precharge_select,
   input wire addrLatchN,
   input wire refresh_tick_clock,
   input wire [ADDR_W-1:0] row_addr_in,
   input wire [ADDR_W-1:0] col_addr_in,
   output reg accessGrant,
   output reg rowStrobeN,
   output reg colStrobeN,
   output reg transfer_ack_n,
   output reg transferAckOe,
   output wire [ADDR_W-1:0] dram_addr_out
);
   localparam integer RAS_LAST_I = `RAS_PULSE_TICKS - 1;
   localparam integer ACK_LAST_I = `ACK_DELAY_TICKS - 1;
   localparam integer CAS_LAST_I = `CAS_DELAY_TICKS - 1;
   localparam integer COL_FULL_I = `COL_DELAY_FULL_TICKS - 1;
   localparam integer COL_HALF_I = `COL_DELAY_HALF_TICKS - 1;
   localparam integer PRE_LONG_I = `PRECH_LONG_TICKS - 1;
   localparam integer PRE_SHORT_I = `PRECH_SHORT_TICKS - 1;
   // counter compare values cut to the counter width on purpose
   localparam [CNT_W-1:0] RAS_LAST = RAS_LAST_I[CNT_W-1:0];
   localparam [CNT_W-1:0] ACK_LAST = ACK_LAST_I[CNT_W-1:0];
   localparam [CNT_W-1:0] CAS_LAST = CAS_LAST_I[CNT_W-1:0];
   localparam [CNT_W-1:0] COL_FULL = COL_FULL_I[CNT_W-1:0];
   localparam [CNT_W-1:0] COL_HALF = COL_HALF_I[CNT_W-1:0];
   localparam [CNT_W-1:0] PRE_LONG = PRE_LONG_I[CNT_W-1:0];
   localparam [CNT_W-1:0] PRE_SHORT = PRE_SHORT_I[CNT_W-1:0];
   localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

   reg [1:0] state;
   reg [CNT_W-1:0] count;
   reg [CNT_W-1:0] prechCount;
   reg risePhase;
   wire refreshPending;
   wire [ADDR_W-1:0] refreshAddr;
   wire prechOk;
   wire startAccess;
   wire startRefresh;
   wire refreshDone;
   wire selCol;
   wire selRefresh;
   wire [CNT_W-1:0] colAt;
   wire [CNT_W-1:0] prechNeed;

   assign prechNeed = precharge_select ? PRE_SHORT : PRE_LONG;
   assign prechOk = rowStrobeN && (prechCount >= prechNeed);
   // the request is only looked at on the rising phase of main_clock
   assign startAccess = (state == `ST_IDLE) && prechOk && risePhase &&
      !accessReqN;
   // the internal refresh request is looked at on the falling phase,
   // so whichever request is seen first wins the cycle
   assign startRefresh = (state == `ST_IDLE) && prechOk && !risePhase &&
      refreshPending;
   assign refreshDone = (state == `ST_REF_RAS) && (count == RAS_LAST);
   assign colAt = row_hold_select ? COL_HALF : COL_FULL;
   assign selCol = (state == `ST_ACCESS) && (count >= colAt);
   assign selRefresh = startRefresh || (state == `ST_REF_ADDR) ||
      (state == `ST_REF_RAS);

   refresh_tracker #(
      .ADDR_W(ADDR_W),
      .DIV_W(DIV_W),
      .LOG_W(LOG_W)
   ) refresh_unit (
      .clock(clock),
      .srst(srst),
      .refreshTickClock(refresh_tick_clock),
      .refreshDone(refreshDone),
      .refreshPending(refreshPending),
      .refreshAddr(refreshAddr)
   );

   dram_addr_mux #(
      .ADDR_W(ADDR_W)
   ) addr_unit (
      .clock(clock),
      .srst(srst),
      .addrLatchN(addrLatchN),
      .rowAddrIn(row_addr_in),
      .colAddrIn(col_addr_in),
      .refreshAddr(refreshAddr),
      .selCol(selCol),
      .selRefresh(selRefresh),
      .dramAddrOut(dram_addr_out)
   );

   always @(posedge clock) begin
      if (srst) begin
         risePhase <= 1'b1;
         prechCount <= CNT_MAX;
      end else begin
         risePhase <= ~risePhase;
         if (!rowStrobeN) begin
            prechCount <= {CNT_W{1'b0}};
         end else if (prechCount != CNT_MAX) begin
            prechCount <= prechCount + 1'b1;
         end
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         state <= `ST_IDLE;
         count <= {CNT_W{1'b0}};
         accessGrant <= 1'b0;
         rowStrobeN <= 1'b1;
         colStrobeN <= 1'b1;
         transfer_ack_n <= 1'b1;
         transferAckOe <= 1'b0;
      end else begin
         case (state)
            `ST_IDLE: begin
               count <= {CNT_W{1'b0}};
               transferAckOe <= 1'b0;
               if (startAccess) begin
                  state <= `ST_ACCESS;
                  rowStrobeN <= 1'b0;
                  accessGrant <= 1'b1;
                  transferAckOe <= 1'b1;
               end else if (startRefresh) begin
                  state <= `ST_REF_ADDR;
               end
            end
            `ST_ACCESS: begin
               if (count != CNT_MAX) begin
                  count <= count + 1'b1;
               end
               if (accessReqN) begin
                  // request released: end everything and go off the bus
                  state <= `ST_IDLE;
                  rowStrobeN <= 1'b1;
                  colStrobeN <= 1'b1;
                  accessGrant <= 1'b0;
                  transfer_ack_n <= 1'b1;
                  transferAckOe <= 1'b0;
               end else begin
                  if (count == CAS_LAST) begin
                     colStrobeN <= 1'b0;
                  end
                  if (count == ACK_LAST) begin
                     transfer_ack_n <= 1'b0;
                  end
                  // page hold low keeps the strobe; once it rises after
                  // the normal pulse length the strobe ends
                  if (count >= RAS_LAST && pageHoldN) begin
                     rowStrobeN <= 1'b1;
                  end
               end
            end
            `ST_REF_ADDR: begin
               state <= `ST_REF_RAS;
               rowStrobeN <= 1'b0;
               count <= {CNT_W{1'b0}};
            end
            `ST_REF_RAS: begin
               count <= count + 1'b1;
               if (count == RAS_LAST) begin
                  rowStrobeN <= 1'b1;
                  state <= `ST_IDLE;
               end
            end
            default: begin
               state <= `ST_IDLE;
               rowStrobeN <= 1'b1;
               colStrobeN <= 1'b1;
               accessGrant <= 1'b0;
               transfer_ack_n <= 1'b1;
               transferAckOe <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ==== logic/dram_addr_mux.v ====
`timescale 1ns/10ps
`include "dram_ctrl_defines.vh"

module dram_addr_mux #(
   parameter ADDR_W = 10
) (
   input wire clock,
   input wire srst,
   input wire addrLatchN,
   input wire [ADDR_W-1:0] rowAddrIn,
   input wire [ADDR_W-1:0] colAddrIn,
   input wire [ADDR_W-1:0] refreshAddr,
   input wire selCol,
   input wire selRefresh,
   output reg [ADDR_W-1:0] dramAddrOut
);
   reg [ADDR_W-1:0] rowHeld;
   reg [ADDR_W-1:0] colHeld;
   wire [ADDR_W-1:0] rowNow;
   wire [ADDR_W-1:0] colNow;

   // low latch control: inputs flow through; high: last values held
   assign rowNow = addrLatchN ? rowHeld : rowAddrIn;
   assign colNow = addrLatchN ? colHeld : colAddrIn;

   always @(posedge clock) begin
      if (srst) begin
         rowHeld <= {ADDR_W{1'b0}};
         colHeld <= {ADDR_W{1'b0}};
         dramAddrOut <= {ADDR_W{1'b0}};
      end else begin
         rowHeld <= rowNow;
         colHeld <= colNow;
         if (selRefresh) begin
            dramAddrOut <= refreshAddr;
         end else if (selCol) begin
            dramAddrOut <= colNow;
         end else begin
            dramAddrOut <= rowNow;
         end
      end
   end
endmodule

// ==== logic/dram_ctrl_defines.vh ====
`ifndef DRAM_CTRL_DEFINES_VH
`define DRAM_CTRL_DEFINES_VH

// one main_clock period is two ticks of clock (half-period resolution)
`define TICKS_PER_MAIN 2
// timing in ticks
`define RAS_PULSE_TICKS (4 * `TICKS_PER_MAIN)
`define ACK_DELAY_TICKS (4 * `TICKS_PER_MAIN)
`define CAS_DELAY_TICKS 3
`define COL_DELAY_FULL_TICKS (1 * `TICKS_PER_MAIN)
`define COL_DELAY_HALF_TICKS 1
`define PRECH_LONG_TICKS (4 * `TICKS_PER_MAIN)
`define PRECH_SHORT_TICKS (3 * `TICKS_PER_MAIN)
// refresh
`define REFRESH_DIVIDE 64
`define REFRESH_LOG_MAX 128
// state codes
`define ST_IDLE 2'd0
`define ST_ACCESS 2'd1
`define ST_REF_ADDR 2'd2
`define ST_REF_RAS 2'd3

`endif

// ==== logic/refresh_tracker.v ====
`timescale 1ns/10ps
`include "dram_ctrl_defines.vh"

module refresh_tracker #(
   parameter ADDR_W = 10,
   parameter DIV_W = 6,
   parameter LOG_W = 8
) (
   input wire clock,
   input wire srst,
   input wire refreshTickClock,
   input wire refreshDone,
   output reg refreshPending,
   output reg [ADDR_W-1:0] refreshAddr
);
   localparam integer DIV_LAST_I = `REFRESH_DIVIDE - 1;
   localparam integer LOG_MAX_I = `REFRESH_LOG_MAX;
   localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_I[DIV_W-1:0];
   localparam [LOG_W-1:0] LOG_MAX = LOG_MAX_I[LOG_W-1:0];

   reg tickMeta;
   reg tickSync;
   reg tickLast;
   reg [DIV_W-1:0] divCount;
   reg [LOG_W-1:0] pendCount;
   wire tickRise;
   wire divWrap;
   wire logInc;
   wire logDec;
   reg [LOG_W-1:0] next_pendCount;

   assign tickRise = tickSync & ~tickLast;
   assign divWrap = tickRise && (divCount == DIV_LAST);
   assign logInc = divWrap && (pendCount < LOG_MAX);
   assign logDec = refreshDone && (pendCount != {LOG_W{1'b0}});

   // a new request in the same tick as a served one is kept
   always @* begin
      next_pendCount = pendCount;
      if (logInc && !logDec) begin
         next_pendCount = pendCount + 1'b1;
      end else if (logDec && !logInc) begin
         next_pendCount = pendCount - 1'b1;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         tickMeta <= 1'b0;
         tickSync <= 1'b0;
         tickLast <= 1'b0;
         divCount <= {DIV_W{1'b0}};
         pendCount <= {LOG_W{1'b0}};
         refreshPending <= 1'b0;
         refreshAddr <= {ADDR_W{1'b1}};
      end else begin
         tickMeta <= refreshTickClock;
         tickSync <= tickMeta;
         tickLast <= tickSync;
         if (tickRise) begin
            divCount <= divWrap ? {DIV_W{1'b0}} : divCount + 1'b1;
         end
         pendCount <= next_pendCount;
         refreshPending <= (next_pendCount != {LOG_W{1'b0}});
         if (refreshDone) begin
            refreshAddr <= refreshAddr + 1'b1;
         end
      end
   end
endmodule

// ==== verification/dram_ctrl_props.sv ====
`timescale 1ns/10ps
module dram_ctrl_props(
   input wire clock,
   input wire srst,
   input wire accessReqN,
   input wire pageHoldN,
   input wire precharge_select,
   input wire accessGrant,
   input wire rowStrobeN,
   input wire colStrobeN,
   input wire transfer_ack_n,
   input wire transferAckOe
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence accStart;
      $fell(rowStrobeN) && accessGrant;
   endsequence
   sequence refStart;
      $fell(rowStrobeN) && !accessGrant;
   endsequence
   a_cas_delay: assert property (accStart ##0 (!accessReqN)[*3]
      |=> !colStrobeN && $past(colStrobeN)) else $error("cas delay");
   a_ack_delay: assert property (accStart ##0 (!accessReqN)[*8]
      |=> !transfer_ack_n && transferAckOe && $past(transfer_ack_n))
      else $error("ack delay");
   a_ras_width: assert property (accStart ##0 (!accessReqN)[*8]
      ##0 pageHoldN |=> rowStrobeN && !$past(rowStrobeN, 2))
      else $error("ras width");
   a_page_hold: assert property (!rowStrobeN && !pageHoldN
      && !accessReqN && accessGrant |=> !rowStrobeN) else $error("page");
   a_release_idle: assert property (accessGrant && accessReqN
      |=> rowStrobeN && colStrobeN && !accessGrant && !transferAckOe)
      else $error("release");
   a_refresh_width: assert property (refStart
      |-> !rowStrobeN[*8] ##1 rowStrobeN && !accessGrant)
      else $error("refresh width");
   a_prech_short: assert property ($rose(rowStrobeN)
      && !$past(srst) |-> rowStrobeN[*6]) else $error("precharge");
   a_prech_long: assert property ($rose(rowStrobeN)
      && !precharge_select && !$past(srst) |-> rowStrobeN[*8])
      else $error("long precharge");
   a_reset_idle: assert property ($fell(srst) |-> rowStrobeN
      && colStrobeN && !accessGrant && !transferAckOe) else $error("reset");
endmodule
bind dram_access_refresh_ctrl dram_ctrl_props i_props(
   .clock(clock), .srst(srst), .accessReqN(accessReqN),
   .pageHoldN(pageHoldN), .precharge_select(precharge_select),
   .accessGrant(accessGrant), .rowStrobeN(rowStrobeN),
   .colStrobeN(colStrobeN), .transfer_ack_n(transfer_ack_n),
   .transferAckOe(transferAckOe));

// ==== verification/dram_requester.sv ====
`timescale 1ns/10ps
module dram_requester(
   input wire clock,
   input wire start,
   input wire [15:0] extra,
   input wire ackLine,
   output reg accessReqN,
   output reg done
);
   integer k;
   initial begin
      accessReqN = 1'b1;
      done = 1'b0;
   end
   // start is looked at on each rising edge while idle; the request stays low
   // until acknowledged plus extra cycles, then done pulses one cycle
   always begin
      @(posedge clock);
      if (start === 1'b1) begin
         #2 accessReqN = 1'b0;
         k = 0;
         while (ackLine !== 1'b0 && k < 64) begin
            @(posedge clock) #2 k = k + 1;
         end
         repeat (extra) @(posedge clock);
         #2 accessReqN = 1'b1;
         @(posedge clock) #1 done = 1'b1;
         @(posedge clock) #1 done = 1'b0;
      end
   end
endmodule

// ==== verification/tb_dram_access_refresh_ctrl.sv ====
`timescale 1ns/10ps
module tb_dram_access_refresh_ctrl;
   reg clock = 0, srst = 1, pageHoldN = 1, row_hold_select = 0, start = 0;
   reg precharge_select = 0, addrLatchN = 0, refTick = 0, refTickOn = 0;
   reg [9:0] row_addr_in = 10'h000, col_addr_in = 10'h000;
   reg [9:0] latR = 10'h000, latC = 10'h000, expRef = 10'h3ff;
   reg [15:0] extra = 16'h0000;
   wire accessGrant, rowStrobeN, colStrobeN, transfer_ack_n;
   wire transferAckOe, accessReqN, done;
   wire [9:0] dram_addr_out;
   // acknowledge line is pulled up while not driven
   wire ackLine = transferAckOe ? transfer_ack_n : 1'b1;
   wire [9:0] idleView = {5'h00, accessGrant, rowStrobeN, colStrobeN,
      transfer_ack_n, transferAckOe};
   integer n_mismatch = 0, checks_done = 0, refCount = 0, n, i;
   always #20 clock = ~clock;
   always @(posedge clock) if (refTickOn) refTick <= #2 ~refTick;
   always @(posedge clock) if (!addrLatchN) begin
      latR <= row_addr_in;
      latC <= col_addr_in;
   end
   dram_access_refresh_ctrl i_dut(.clock(clock), .srst(srst),
      .accessReqN(accessReqN), .pageHoldN(pageHoldN),
      .row_hold_select(row_hold_select),
      .precharge_select(precharge_select), .addrLatchN(addrLatchN),
      .refresh_tick_clock(refTick), .row_addr_in(row_addr_in),
      .col_addr_in(col_addr_in), .accessGrant(accessGrant),
      .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
      .transfer_ack_n(transfer_ack_n), .transferAckOe(transferAckOe),
      .dram_addr_out(dram_addr_out));
   dram_requester i_req(.clock(clock), .start(start), .extra(extra),
      .ackLine(ackLine), .accessReqN(accessReqN), .done(done));
   task chk(input [9:0] got, input [9:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: %h %h", $time, got, exp);
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_mismatch);
         if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task tick;
      begin
         @(posedge clock);
         #2;
      end
   endtask
   task bound(input integer used, input integer lim);
      begin
         if (used >= lim) begin
            n_mismatch = n_mismatch + 1;
            results;
         end
      end
   endtask
   task waitDone;
      begin
         n = 0;
         while (done !== 1'b1 && n < 1000) begin
            tick;
            n = n + 1;
         end
         start = 0;
         bound(n, 1000);
         tick;
      end
   endtask
   task acc(input [9:0] r, input [9:0] c, input h);
      begin
         row_addr_in = r;
         col_addr_in = c;
         row_hold_select = h;
         extra = 16'h0002;
         start = 1;
         n = 0;
         while (accessGrant !== 1'b1 && n < 40) begin
            tick;
            n = n + 1;
         end
         bound(n, 40);
         chk(dram_addr_out, latR);
         tick;
         chk(dram_addr_out, h ? latC : latR);
         tick;
         chk(dram_addr_out, latC);
         n = 2;
         while (ackLine !== 1'b0 && n < 40) begin
            tick;
            n = n + 1;
         end
         bound(n, 40);
         chk(n[9:0], 10'h008);
         waitDone;
         chk(idleView, 10'h00e);
      end
   endtask
   always @(negedge rowStrobeN) begin
      #1;
      if (!accessGrant) begin
         chk(dram_addr_out, expRef);
         expRef = expRef + 10'h001;
         refCount = refCount + 1;
      end
   end
   initial begin
      #3000000;
      n_mismatch = n_mismatch + 1;
      results;
   end
   initial begin
      repeat (12) @(posedge clock);
      #2 srst = 0;
      chk(idleView, 10'h00e);
      for (i = 0; i < 4; i = i + 1) begin
         if (i == 2) repeat (10) tick;
         precharge_select = i[1];
         acc(10'h155 + i[9:0], 10'h2aa - i[9:0], i[0]);
         $display("access test %0d done", i);
      end
      row_addr_in = 10'h0f0;
      col_addr_in = 10'h00f;
      repeat (2) tick;
      addrLatchN = 1;
      acc(10'h3c3, 10'h1e1, 1'b1);
      $display("latch test done");
      pageHoldN = 0;
      extra = 16'd600;
      start = 1;
      refTickOn = 1;
      repeat (384) @(posedge clock);
      #2 refTickOn = 0;
      chk(refCount[9:0], 10'h000);
      chk({9'h000, rowStrobeN}, 10'h000);
      pageHoldN = 1;
      tick;
      chk({9'h000, rowStrobeN}, 10'h001);
      waitDone;
      n = 0;
      while (refCount < 3 && n < 200) begin
         tick;
         n = n + 1;
      end
      bound(n, 200);
      repeat (40) tick;
      chk(refCount[9:0], 10'h003);
      $display("refresh burst test done");
      results;
   end
endmodule
